// file: logic/cam_pkg.sv
/*
 * Constants, register map and field layout of the counter array module
 * control block.
 * Assumes a 100 MHz system clock and an AXI4-Lite master with 32-bit data.
 */
// Overview of operation
// - Match enable sets module flag when counter equals compare value.
// - Toggle enable inverts module pin when counter equals compare value.
// - Toggle and pulse-width enables together select frequency output mode.
// - Counter low byte is readable and writable by software.
// - Each of five modules has a readable, writable compare high byte.
// - Counter low read latches high byte for the following high read.
// - Counter wrap always sets overflow flag, even during a control write.

`default_nettype none

package cam_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_MOD = 5;
	localparam int ADDR_W  = 10;
	localparam int DATA_W  = 32;

	// ----------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [NUM_MOD-1:0][7:0] IDX_CAP_HI =
		{8'hFE, 8'hEE, 8'hEC, 8'hEA, 8'hFC};
	localparam logic [NUM_MOD-1:0][7:0] IDX_CAP_LO =
		{8'hE4, 8'hE3, 8'hE2, 8'hE1, 8'hE0};
	localparam logic [NUM_MOD-1:0][7:0] IDX_MODE =
		{8'hDE, 8'hDD, 8'hDC, 8'hDB, 8'hDA};
	localparam logic [7:0] IDX_CNT_LO = 8'hF9;
	localparam logic [7:0] IDX_CNT_HI = 8'hFA;
	localparam logic [7:0] IDX_CTRL   = 8'hD8;

	// ----------------------------------------------------------------
	// Mode register fields
	// ----------------------------------------------------------------
	localparam int MODE_WIDE_BIT  = 7;
	localparam int MODE_FALL_BIT  = 4;
	localparam int MODE_MATCH_BIT = 3;
	localparam int MODE_TOG_BIT   = 2;
	localparam int MODE_PWM_BIT   = 1;
	localparam int MODE_MASK_BIT  = 0;

	// ----------------------------------------------------------------
	// Control register fields: flags in 4:0
	// ----------------------------------------------------------------
	localparam int CTRL_OVF_BIT = 7;
	localparam int CTRL_RUN_BIT = 6;

	// ----------------------------------------------------------------
	// Reset values, limits and responses
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [15:0] RST_CNT     = 16'h0000;
	localparam logic [15:0] CNT_MAX     = 16'hFFFF;
	localparam logic [7:0]  BYTE_MAX    = 8'hFF;
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
		return {idx, 2'b00};
	endfunction : byte_addr

endpackage : cam_pkg

`default_nettype wire

// file: logic/cam_ctl.sv
/*
 * Counter array module control: shared 16-bit counter, five compare
 * modules with match, toggle, frequency output and PWM, behind an
 * AXI4-Lite register slave.
 * Assumes one system clock, a synchronous active-low reset and a master
 * that keeps AXI4-Lite handshake rules.
 */
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module cam_ctl
(
	// Clock, reset, enable
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic                          clk_en,
	// AXI4-Lite write address
	input  wire logic [cam_pkg::ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [cam_pkg::DATA_W-1:0]    s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [cam_pkg::ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	// AXI4-Lite read data
	output logic [cam_pkg::DATA_W-1:0]         s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// Module outputs and flags
	output logic [cam_pkg::NUM_MOD-1:0]        module_output_pin,
	output logic [cam_pkg::NUM_MOD-1:0]        compare_event_flag,
	output logic                               counter_overflow_flag
);

	import cam_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0]               counter;
		logic [7:0]                high_snap;
		logic [NUM_MOD-1:0][7:0]   cap_hi;
		logic [NUM_MOD-1:0][7:0]   cap_lo;
		logic [NUM_MOD-1:0][7:0]   mode;
		logic [NUM_MOD-1:0]        flag;
		logic                      ovf;
		logic                      run;
		logic [NUM_MOD-1:0]        pin;
		logic                      aw_hold;
		logic [ADDR_W-1:0]         aw_addr;
		logic                      w_hold;
		logic [7:0]                w_byte;
		logic                      w_lane;
		logic                      bvalid;
		logic [1:0]                bresp;
		logic                      rvalid;
		logic [1:0]                rresp;
		logic [DATA_W-1:0]         rdata;
	} cam_state_type;

	cam_state_type st_ff;
	cam_state_type nxt_st;

	// ----------------------------------------------------------------
	// Per-module compare detection
	// ----------------------------------------------------------------
	logic [NUM_MOD-1:0] full_match;
	logic [NUM_MOD-1:0] low_match;
	logic [NUM_MOD-1:0] wide_high;
	logic [NUM_MOD-1:0] narrow_high;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_MOD; gi++)
		begin : g_mod
			assign full_match[gi]  = st_ff.counter ==
				{st_ff.cap_hi[gi], st_ff.cap_lo[gi]};
			assign low_match[gi]   = st_ff.counter[7:0] == st_ff.cap_lo[gi];
			assign wide_high[gi]   = st_ff.counter >=
				{st_ff.cap_hi[gi], st_ff.cap_lo[gi]};
			assign narrow_high[gi] = st_ff.counter[7:0] >= st_ff.cap_lo[gi];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Handshakes
	// ----------------------------------------------------------------
	// Ready drops with the clock enable so no beat is taken while frozen
	assign s_axi_awready = clk_en & ~st_ff.aw_hold & ~st_ff.bvalid;
	assign s_axi_wready  = clk_en & ~st_ff.w_hold & ~st_ff.bvalid;
	assign s_axi_arready = clk_en & ~st_ff.rvalid;

	logic hs_aw;
	logic hs_w;
	logic hs_ar;

	assign hs_aw = s_axi_awvalid & s_axi_awready;
	assign hs_w  = s_axi_wvalid & s_axi_wready;
	assign hs_ar = s_axi_arvalid & s_axi_arready;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic                  do_wr;
		logic [ADDR_W-1:0]     wa;
		logic [7:0]            wb;
		logic                  wl;
		logic                  hit;
		logic [NUM_MOD-1:0]    set_flag;
		logic                  set_ovf;
		logic [7:0]            rb;
		logic                  rhit;

		do_wr    = 1'b0;
		wa       = '0;
		wb       = RST_BYTE;
		wl       = 1'b0;
		hit      = 1'b0;
		set_flag = '0;
		set_ovf  = 1'b0;
		rb       = RST_BYTE;
		rhit     = 1'b0;
		nxt_st   = st_ff;

		// ------------------------------------------------------------
		// Counter and module outputs
		// ------------------------------------------------------------
		if (st_ff.run)
		begin
			nxt_st.counter = st_ff.counter + 16'h0001;
			if (st_ff.counter == CNT_MAX)
				set_ovf = 1'b1;
		end

		for (int i = 0; i < NUM_MOD; i++)
		begin
			if (st_ff.run)
			begin
				if (st_ff.mode[i][MODE_TOG_BIT] && st_ff.mode[i][MODE_PWM_BIT])
				begin
					// Frequency output: toggle and step the low compare on the same edge
					if (low_match[i])
					begin
						nxt_st.pin[i]    = ~st_ff.pin[i];
						nxt_st.cap_lo[i] = st_ff.cap_lo[i] + st_ff.cap_hi[i];
					end
				end
				else if (st_ff.mode[i][MODE_PWM_BIT])
				begin
					if (st_ff.mode[i][MODE_WIDE_BIT])
						nxt_st.pin[i] = wide_high[i];
					else
					begin
						nxt_st.pin[i] = narrow_high[i];
						// Duty reloads only at low byte wrap: no glitches
						if (st_ff.counter[7:0] == BYTE_MAX)
							nxt_st.cap_lo[i] = st_ff.cap_hi[i];
					end
				end
				else if (st_ff.mode[i][MODE_TOG_BIT] && full_match[i])
					nxt_st.pin[i] = ~st_ff.pin[i];
				if (st_ff.mode[i][MODE_MATCH_BIT] && full_match[i])
					set_flag[i] = 1'b1;
			end
		end

		// ------------------------------------------------------------
		// Write channel
		// ------------------------------------------------------------
		if (hs_aw)
		begin
			nxt_st.aw_hold = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr;
		end
		if (hs_w)
		begin
			nxt_st.w_hold = 1'b1;
			nxt_st.w_byte = s_axi_wdata[7:0];
			nxt_st.w_lane = s_axi_wstrb[0];
		end

		if ((st_ff.aw_hold || hs_aw) && (st_ff.w_hold || hs_w) && !st_ff.bvalid)
		begin
			do_wr = 1'b1;
			wa    = st_ff.aw_hold ? st_ff.aw_addr : s_axi_awaddr;
			wb    = st_ff.w_hold ? st_ff.w_byte : s_axi_wdata[7:0];
			wl    = st_ff.w_hold ? st_ff.w_lane : s_axi_wstrb[0];
		end

		if (do_wr)
		begin
			nxt_st.aw_hold = 1'b0;
			nxt_st.w_hold  = 1'b0;
			nxt_st.bvalid  = 1'b1;
			if (wa == byte_addr(IDX_CNT_LO))
			begin
				hit = 1'b1;
				if (wl)
					nxt_st.counter[7:0] = wb;
			end
			else if (wa == byte_addr(IDX_CNT_HI))
			begin
				hit = 1'b1;
				if (wl)
					nxt_st.counter[15:8] = wb;
			end
			else if (wa == byte_addr(IDX_CTRL))
			begin
				hit = 1'b1;
				if (wl)
				begin
					nxt_st.ovf  = wb[CTRL_OVF_BIT];
					nxt_st.run  = wb[CTRL_RUN_BIT];
					nxt_st.flag = wb[NUM_MOD-1:0];
				end
			end
			else
			begin
				for (int i = 0; i < NUM_MOD; i++)
				begin
					if (wa == byte_addr(IDX_CAP_HI[i]))
					begin
						hit = 1'b1;
						if (wl)
							nxt_st.cap_hi[i] = wb;
					end
					if (wa == byte_addr(IDX_CAP_LO[i]))
					begin
						hit = 1'b1;
						if (wl)
							nxt_st.cap_lo[i] = wb;
					end
					if (wa == byte_addr(IDX_MODE[i]))
					begin
						hit = 1'b1;
						if (wl)
							nxt_st.mode[i] = wb;
					end
				end
			end
			nxt_st.bresp = hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (st_ff.bvalid && s_axi_bready)
			nxt_st.bvalid = 1'b0;

		// Hardware sets land after the write so an event is never lost
		nxt_st.flag = nxt_st.flag | set_flag;
		nxt_st.ovf  = nxt_st.ovf | set_ovf;

		// ------------------------------------------------------------
		// Read channel
		// ------------------------------------------------------------
		if (hs_ar)
		begin
			if (s_axi_araddr == byte_addr(IDX_CNT_LO))
			begin
				rhit = 1'b1;
				rb   = st_ff.counter[7:0];
				nxt_st.high_snap = st_ff.counter[15:8];
			end
			else if (s_axi_araddr == byte_addr(IDX_CNT_HI))
			begin
				rhit = 1'b1;
				rb   = st_ff.high_snap;
			end
			else if (s_axi_araddr == byte_addr(IDX_CTRL))
			begin
				rhit = 1'b1;
				rb   = {st_ff.ovf, st_ff.run, 1'b0, st_ff.flag};
			end
			else
			begin
				for (int i = 0; i < NUM_MOD; i++)
				begin
					if (s_axi_araddr == byte_addr(IDX_CAP_HI[i]))
					begin
						rhit = 1'b1;
						rb   = st_ff.cap_hi[i];
					end
					if (s_axi_araddr == byte_addr(IDX_CAP_LO[i]))
					begin
						rhit = 1'b1;
						rb   = st_ff.cap_lo[i];
					end
					if (s_axi_araddr == byte_addr(IDX_MODE[i]))
					begin
						rhit = 1'b1;
						rb   = st_ff.mode[i];
					end
				end
			end
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata  = {24'h00_0000, rb};
			nxt_st.rresp  = rhit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (st_ff.rvalid && s_axi_rready)
			nxt_st.rvalid = 1'b0;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_ff.counter   <= RST_CNT;
			st_ff.high_snap <= RST_BYTE;
			st_ff.cap_hi    <= '0;
			st_ff.cap_lo    <= '0;
			st_ff.mode      <= '0;
			st_ff.flag      <= '0;
			st_ff.ovf       <= 1'b0;
			st_ff.run       <= 1'b0;
			st_ff.pin       <= '0;
			st_ff.aw_hold   <= 1'b0;
			st_ff.aw_addr   <= '0;
			st_ff.w_hold    <= 1'b0;
			st_ff.w_byte    <= RST_BYTE;
			st_ff.w_lane    <= 1'b0;
			st_ff.bvalid    <= 1'b0;
			st_ff.bresp     <= RESP_OKAY;
			st_ff.rvalid    <= 1'b0;
			st_ff.rresp     <= RESP_OKAY;
			st_ff.rdata     <= '0;
		end
		else if (clk_en)
			st_ff <= nxt_st;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_bvalid          = st_ff.bvalid;
	assign s_axi_bresp           = st_ff.bresp;
	assign s_axi_rvalid          = st_ff.rvalid;
	assign s_axi_rresp           = st_ff.rresp;
	assign s_axi_rdata           = st_ff.rdata;
	assign module_output_pin     = st_ff.pin;
	assign compare_event_flag    = st_ff.flag;
	assign counter_overflow_flag = st_ff.ovf;

endmodule : cam_ctl

`default_nettype wire

// file: dv/cam_ctl_assertions.sv
/* Port checker for cam_ctl.
   Assumes a bind to cam_ctl; one clock, synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module cam_ctl_chk
(
	// Clock and control
	input wire logic                       aclk,
	input wire logic                       aresetn,
	input wire logic                       clk_en,
	// Bus handshakes
	input wire logic                       s_axi_awvalid,
	input wire logic                       s_axi_awready,
	input wire logic                       s_axi_wvalid,
	input wire logic                       s_axi_wready,
	input wire logic                       s_axi_bvalid,
	input wire logic                       s_axi_arvalid,
	input wire logic                       s_axi_arready,
	input wire logic                       s_axi_rvalid,
	// Module outputs
	input wire logic [cam_pkg::NUM_MOD-1:0] module_output_pin,
	input wire logic [cam_pkg::NUM_MOD-1:0] compare_event_flag,
	input wire logic                       counter_overflow_flag
);
	import cam_pkg::*;
	// Write may land at either channel's edge
	logic take;
	assign take = (s_axi_wvalid && s_axi_wready)
		|| (s_axi_awvalid && s_axi_awready);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_rd_latency:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_rd_cause:
		assert property ($rose(s_axi_rvalid) |->
			$past(s_axi_arvalid && s_axi_arready))
		else $error("read answer without request");
	chk_wr_cause:
		assert property ($rose(s_axi_bvalid) |-> $past(take))
		else $error("write answer without request");
	chk_stall_refuse:
		assert property (!clk_en |->
			!s_axi_awready && !s_axi_wready && !s_axi_arready)
		else $error("ready while stalled");
	chk_flag_sticky:
		assert property (!take |=> (compare_event_flag &
			$past(compare_event_flag)) == $past(compare_event_flag))
		else $error("compare flag dropped");
	chk_ovf_sticky:
		assert property (!take |=> !$fell(counter_overflow_flag))
		else $error("overflow flag dropped");
	chk_stall_frozen:
		assert property (!clk_en |=> $stable(module_output_pin)
			&& $stable(compare_event_flag))
		else $error("outputs moved while stalled");
	chk_reset_clear:
		assert property (disable iff (1'b0) !aresetn |=>
			module_output_pin == '0 && compare_event_flag == '0
			&& !counter_overflow_flag && !s_axi_bvalid && !s_axi_rvalid)
		else $error("state not cleared by reset");
	cover property (counter_overflow_flag);
	cover property ($rose(module_output_pin[1]));
	cover property (!clk_en ##1 clk_en);
endmodule : cam_ctl_chk
`default_nettype wire

// file: dv/cam_pin_load.sv
/* Load on the module output pins: counts level changes per pin.
   Assumes pins sampled on the system clock. */
`timescale 1ns/1ps
`default_nettype none
module cam_pin_load
(
	// Clock and reset
	input wire logic                          aclk,
	input wire logic                          aresetn,
	// Observed pins and their edge counts
	input wire logic [cam_pkg::NUM_MOD-1:0]   pin,
	output logic [cam_pkg::NUM_MOD-1:0][15:0] edges
);
	import cam_pkg::*;
	logic [NUM_MOD-1:0] last;
	always @(posedge aclk)
	begin
		last <= aresetn ? pin : '0;
		for (int i = 0; i < NUM_MOD; i++)
			edges[i] <= aresetn ? edges[i] + 16'(pin[i] != last[i]) : '0;
	end
endmodule : cam_pin_load
`default_nettype wire

// file: dv/test_cam_ctl.sv
/* Self-checking bench for cam_ctl with a pin load.
   Assumes cam_pkg, cam_pin_load and cam_ctl_chk compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_cam_ctl;
	import cam_pkg::*;
	localparam logic [7:0] MV [NUM_MOD] = '{8'h0C, 8'h06, 8'h02, 8'h82, 8'h00};
	localparam logic [7:0] LV [NUM_MOD] = '{8'h20, 8'h10, 8'h80, 8'h00, 8'h00};
	localparam logic [7:0] HV [NUM_MOD] = '{8'h00, 8'h10, 8'h80, 8'h01, 8'h00};
	logic                     aclk = 0, aresetn = 0, clk_en = 1;
	logic                     awvalid = 0, wvalid = 0, arvalid = 0;
	logic [ADDR_W-1:0]        awaddr = '0, araddr = '0;
	logic [DATA_W-1:0]        wdata = '0, rdata;
	logic                     awready, wready, arready, bvalid, rvalid;
	logic [1:0]               bresp, rresp;
	logic [NUM_MOD-1:0]       pins, flags;
	logic                     ovf;
	logic [3:0]               wstrb = 4'h1;
	int                       ovf_hits = 0, h = 0;
	logic [NUM_MOD-1:0][15:0] edges;
	logic [31:0]              rs = 32'h8a25_910d;
	logic [34:0]              rq [$];
	logic [1:0]               bq [$];
	logic [7:0]               v, lo, hi;
	logic [15:0]              c;
	int                       fail_count = 0, num_checks = 0;
	always #5 aclk = ~aclk;
	cam_ctl u_cam_ctl (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(1'b1), .module_output_pin(pins),
		.compare_event_flag(flags), .counter_overflow_flag(ovf));
	cam_pin_load u_cam_pin_load (.aclk(aclk), .aresetn(aresetn),
		.pin(pins), .edges(edges));
	// ----------------------------------------
	// Helpers and bus tasks
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	function automatic logic [34:0] ok(input logic [7:0] x);
		return {1'b1, RESP_OKAY, 24'h00_0000, x};
	endfunction : ok
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	task automatic wr(input logic [7:0] idx, input logic [7:0] d,
		input logic [1:0] er);
		bq.push_back(er);
		awaddr <= byte_addr(idx);
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (int n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) return;
		end
		fail_count++;
		wrap_up();
	endtask : wr
	task automatic rd(input logic [7:0] idx, input logic [34:0] e,
		output logic [7:0] d);
		rq.push_back(e);
		araddr <= byte_addr(idx);
		arvalid <= 1'b1;
		for (int n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			d = rdata[7:0];
			if (rvalid) return;
		end
		fail_count++;
		wrap_up();
	endtask : rd
	// Result watcher: oldest note against each answer
	always @(posedge aclk)
	begin
		if (ovf) ovf_hits <= ovf_hits + 1;
		if (bvalid) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
		if (rvalid && rq[0][34]) chk({rresp, rdata}, rq[0][33:0]);
		if (rvalid) void'(rq.pop_front());
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int m = 0; m < NUM_MOD; m++)
		begin
			rs = xs(rs);
			rd(IDX_CAP_HI[m], ok(RST_BYTE), v);
			wr(IDX_CAP_HI[m], rs[7:0], RESP_OKAY);
			rd(IDX_CAP_HI[m], ok(rs[7:0]), v);
		end
		// Lane 0 off: the write is answered but must not land
		wstrb <= 4'h0;
		wr(IDX_CAP_HI[4], ~rs[7:0], RESP_OKAY);
		wstrb <= 4'h1;
		rd(IDX_CAP_HI[4], ok(rs[7:0]), v);
		rs = xs(rs);
		wr(IDX_CNT_LO, rs[7:0], RESP_OKAY);
		rd(IDX_CNT_LO, ok(rs[7:0]), v);
		wr(IDX_CNT_LO, RST_BYTE, RESP_OKAY);
		wr(8'h01, rs[7:0], RESP_SLVERR);
		rd(8'h01, {1'b1, RESP_SLVERR, 32'h0000_0000}, v);
		$display("registers done");
		for (int m = 0; m < NUM_MOD; m++)
		begin
			wr(IDX_CAP_LO[m], LV[m], RESP_OKAY);
			wr(IDX_CAP_HI[m], HV[m], RESP_OKAY);
			wr(IDX_MODE[m], MV[m], RESP_OKAY);
			rd(IDX_MODE[m], ok(MV[m]), v);
		end
		wr(IDX_CTRL, 8'h40, RESP_OKAY);
		repeat (300) @(posedge aclk);
		clk_en <= 1'b0;
		repeat (5) @(posedge aclk);
		clk_en <= 1'b1;
		repeat (300) @(posedge aclk);
		chk({29'h0, flags}, 34'h1);
		// Snapshot, not the live byte, before any new low read
		rd(IDX_CNT_HI, ok(RST_BYTE), v);
		wr(IDX_CTRL, 8'h00, RESP_OKAY);
		rd(IDX_CNT_LO, '0, lo);
		rd(IDX_CNT_HI, ok(8'h02), hi);
		c = {hi, lo} - 16'h0001;
		chk({29'h0, pins}, {30'h0, c >= 16'h0100, c[7], c[4], 1'b1});
		chk(edges[0], 34'h1);
		chk(edges[1], c / 16);
		chk(edges[2], c / 128);
		chk(edges[3], c >= 16'h0100);
		$display("events done");
		// Writes land every second edge: from F0 the wrap meets one,
		// from F1 it falls between two
		for (int k = 0; k < 2; k++)
		begin
			wr(IDX_CTRL, 8'h00, RESP_OKAY);
			wr(IDX_CNT_HI, BYTE_MAX, RESP_OKAY);
			wr(IDX_CNT_LO, 8'hF0 + 8'(k), RESP_OKAY);
			h = ovf_hits;
			for (int n = 0; n < 20 && ovf_hits == h; n++)
				wr(IDX_CTRL, 8'h40, RESP_OKAY);
			chk(ovf_hits != h, 1'b1);
		end
		$display("overflow done");
		// Mid-run reset held two edges so no check straddles it
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({29'h0, pins}, 34'h0);
		rd(IDX_MODE[1], ok(RST_BYTE), v);
		$display("reset done");
		wrap_up();
	end
endmodule : test_cam_ctl
bind cam_ctl cam_ctl_chk u_cam_ctl_chk (.aclk(aclk), .aresetn(aresetn),
	.clk_en(clk_en), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .module_output_pin(module_output_pin),
	.compare_event_flag(compare_event_flag),
	.counter_overflow_flag(counter_overflow_flag));
`default_nettype wire
